// >>> common/eag_pkg.sv
// Shared constants, carriers and state types of the effective address generator
package eag_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_EA = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_OPW = 8'h10;
  localparam logic [7:0] OFF_EXT = 8'h40;
  localparam logic [7:0] OFF_RF = 8'h80;
  localparam int NUM_EXT = 10; // Extension words after the operation word
  localparam int NUM_RF = 16; // Data registers then address registers
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_SIZE_LO = 1;
  localparam int CTRL_WDEST = 3;
  localparam int CTRL_CP_LO = 8;
  // Mode field codes
  localparam logic [2:0] M_DREG = 3'h0;
  localparam logic [2:0] M_AREG = 3'h1;
  localparam logic [2:0] M_AIND = 3'h2;
  localparam logic [2:0] M_PINC = 3'h3;
  localparam logic [2:0] M_PDEC = 3'h4;
  localparam logic [2:0] M_DISP = 3'h5;
  localparam logic [2:0] M_IDX = 3'h6;
  localparam logic [2:0] M_EXT = 3'h7;
  localparam logic [2:0] SUB_PCD = 3'h2;
  localparam logic [2:0] SUB_PCX = 3'h3;
  // Extension word fields
  localparam int EXT_DA = 15;
  localparam int EXT_RN_LO = 12;
  localparam int EXT_WL = 11;
  localparam int EXT_SC_LO = 9;
  localparam int EXT_FULL = 8;
  localparam int EXT_BS = 7;
  localparam int EXT_IS = 6;
  localparam int EXT_BD_LO = 4;
  localparam int EXT_ZERO = 3;
  localparam logic [1:0] BD_RSV = 2'h0;
  localparam logic [1:0] BD_NULL = 2'h1;
  localparam logic [1:0] BD_WORD = 2'h2;
  localparam logic [1:0] BD_LONG = 2'h3;
  localparam logic [2:0] IIS_NONE = 3'h0;
  localparam logic [2:0] IIS_RSV = 3'h4;
  // Operand sizes and stack pointer
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [2:0] SP_REG = 3'h7;
  localparam logic [7:0] STEP_B = 8'h01;
  localparam logic [7:0] STEP_W = 8'h02;
  localparam logic [7:0] STEP_L = 8'h04;

  typedef logic [NUM_EXT-1:0][15:0] eag_ext_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RBASE = 3'b001,
    S_RIDX = 3'b010,
    S_CALC = 3'b011,
    S_MEM = 3'b100,
    S_WB = 3'b101,
    S_DONE = 3'b110
  } eag_st_t;

  // Result towards operand access logic
  typedef struct packed {
    logic valid;
    logic illegal;
    logic prog;
    logic regop;
    logic [31:0] addr;
  } eag_ea_t;

  // Pointer fetch request for memory indirection
  typedef struct packed {
    logic req;
    logic prog;
    logic [31:0] addr;
  } eag_mem_t;
endpackage

// >>> core/eag_index_calc.sv
// Sized, sign-extended and scaled index operand
`timescale 1ns/1ps
module eag_index_calc import eag_pkg::*; (
  input wire logic [15:0] ext_word,
  input wire logic [31:0] index_val,
  output logic [31:0] scaled
);
  logic [31:0] sized;

  // Word index takes the sign-extended low half
  always_comb begin
    if (ext_word[EXT_WL]) begin
      sized = index_val;
    end else begin
      sized = {{16{index_val[15]}}, index_val[15:0]};
    end
    scaled = sized << ext_word[EXT_SC_LO +: 2];
  end
endmodule // eag_index_calc

// >>> core/eag_regfile.sv
// Register file memory with registered read data
`timescale 1ns/1ps
module eag_regfile import eag_pkg::*; #(
  parameter int DEPTH = NUM_RF,
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Contents need no reset, software loads them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data lands one cycle after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // eag_regfile

// >>> core/eag_top.sv
// Effective address generator with APB register access
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module eag_top import eag_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output eag_mem_t MEM,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output eag_ea_t EA
);
  typedef struct packed {
    eag_st_t st;
    logic [1:0] size;
    logic wdest;
    logic [7:0] cp_size;
    logic [15:0] opw;
    eag_ext_t ext;
    logic [31:0] pc;
    logic [31:0] base;
    logic [31:0] idx;
    logic [31:0] od;
    logic post;
    logic [31:0] ea;
    logic prog;
    logic done;
    logic illegal;
    logic regop;
    logic [3:0] nwords;
    eag_mem_t mem;
    logic [31:0] wb_val;
    logic valid;
    logic [31:0] prdata;
    logic rf_ok;
  } eag_state_t;

  eag_state_t s_r;
  eag_state_t s_nxt;
  logic [31:0] rf_rdata;
  logic [31:0] scaled;
  logic rf_we;
  logic [3:0] rf_waddr;
  logic [3:0] rf_raddr;

  // Operation word and first extension word fields
  logic [2:0] mode;
  logic [2:0] rn;
  logic [15:0] e0;
  logic full;
  logic pcm;
  logic idxm;
  logic [1:0] bdsz;
  logic [2:0] iis;
  logic isup;
  logic rsv;
  logic unsup;
  logic illegal;
  logic [3:0] bdw;
  logic [3:0] odw;
  logic [3:0] nw;
  logic [7:0] step;
  logic [31:0] bd;
  logic [31:0] bt;
  logic [31:0] it;
  logic [31:0] sum;

  // APB decode
  logic setup;
  logic acc;
  logic hit_ext;
  logic hit_rf;
  logic hit;
  logic [3:0] ext_i;
  logic [7:0] ext_off;
  logic [7:0] rf_off;
  logic idle;

  // Sign-extended displacement of null, word or long size at word p
  function automatic logic [31:0] disp(input eag_ext_t e, input logic [3:0] p,
                                       input logic [1:0] c);
    logic [31:0] v;
    v = '0;
    if (c == BD_WORD) begin
      v = {{16{e[p][15]}}, e[p]};
    end else if (c == BD_LONG) begin
      v = {e[p], e[p + 4'h1]};
    end
    return v;
  endfunction

  // Extension words taken by a size code
  function automatic logic [3:0] words(input logic [1:0] c);
    return (c == BD_LONG) ? 4'h2 : ((c == BD_WORD) ? 4'h1 : 4'h0);
  endfunction

  assign mode = s_r.opw[5:3];
  assign rn = s_r.opw[2:0];
  assign e0 = s_r.ext[0];
  assign full = e0[EXT_FULL];
  // Mode 111 picks its sub-mode from the register field
  assign pcm = (mode == M_EXT) && (rn == SUB_PCD || rn == SUB_PCX);
  assign idxm = (mode == M_IDX) || (mode == M_EXT && rn == SUB_PCX);
  assign unsup = (mode == M_EXT) && !pcm;
  assign bdsz = e0[EXT_BD_LO +: 2];
  assign iis = e0[2:0];
  assign isup = e0[EXT_IS];

  // Reserved encodings never produce an address
  assign rsv = full && (bdsz == BD_RSV || e0[EXT_ZERO] || iis == IIS_RSV
               || (isup && iis[2]));
  assign illegal = unsup || (idxm && rsv) || (pcm && s_r.wdest);

  // Extension word count per mode
  assign bdw = words(bdsz);
  assign odw = (iis == IIS_NONE) ? 4'h0 : words(iis[1:0]);
  always_comb begin
    unique case (mode)
      M_DISP: nw = 4'h1;
      M_IDX: nw = full ? 4'h1 + bdw + odw : 4'h1;
      M_EXT: nw = (rn == SUB_PCX && full) ? 4'h1 + bdw + odw : 4'h1;
      default: nw = 4'h0;
    endcase
  end

  // Byte through the stack pointer keeps word alignment unless cp_size sets the step
  always_comb begin
    if (s_r.cp_size != 8'h00) begin
      step = s_r.cp_size;
    end else if (s_r.size == SZ_BYTE) begin
      step = (rn == SP_REG) ? STEP_W : STEP_B;
    end else if (s_r.size == SZ_WORD) begin
      step = STEP_W;
    end else begin
      step = STEP_L;
    end
  end

  // Index register read arrives in the calc state
  eag_index_calc u_idx (
    .ext_word(e0),
    .index_val(rf_rdata),
    .scaled(scaled)
  );

  // Address sum with suppressed elements as zero
  assign bd = full ? disp(s_r.ext, 4'h1, bdsz) : {{24{e0[7]}}, e0[7:0]};
  assign bt = (full && e0[EXT_BS]) ? '0 : s_r.base;
  assign it = (full && isup) ? '0 : scaled;
  assign sum = bt + bd + it;

  // APB address decode
  assign setup = PSEL && !PENABLE;
  assign acc = PSEL && PENABLE;
  assign ext_off = PADDR - OFF_EXT;
  assign rf_off = PADDR - OFF_RF;
  assign hit_ext = PADDR >= OFF_EXT && ext_off < 8'(4 * NUM_EXT) && PADDR[1:0] == 2'h0;
  assign hit_rf = PADDR >= OFF_RF && rf_off < 8'(4 * NUM_RF) && PADDR[1:0] == 2'h0;
  assign ext_i = ext_off[5:2];
  assign hit = hit_ext || hit_rf || PADDR == OFF_CTRL || PADDR == OFF_STAT
               || PADDR == OFF_EA || PADDR == OFF_PC || PADDR == OFF_OPW;
  assign idle = s_r.st == S_IDLE;

  // Writes wait for idle so setup cannot change mid calculation
  assign PREADY = PWRITE ? idle : (!hit_rf || s_r.rf_ok);
  assign PSLVERR = acc && !hit;
  assign PRDATA = hit_rf ? rf_rdata : s_r.prdata;

  // Register file ports shared by the sequencer and software
  assign rf_we = (s_r.st == S_WB) || (acc && PWRITE && hit_rf && idle);
  assign rf_waddr = (s_r.st == S_WB) ? {1'b1, rn} : rf_off[5:2];
  always_comb begin
    unique case (s_r.st)
      S_RBASE: rf_raddr = {1'b1, rn};
      S_RIDX: rf_raddr = {e0[EXT_DA], e0[EXT_RN_LO +: 3]};
      default: rf_raddr = rf_off[5:2];
    endcase
  end

  eag_regfile #(
    .DEPTH(NUM_RF),
    .WIDTH(32)
  ) u_rf (
    .clk(CLOCK),
    .rst(RST),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata((s_r.st == S_WB) ? s_r.wb_val : PWDATA),
    .raddr(rf_raddr),
    .rdata(rf_rdata)
  );

  // Next state: software access and sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.rf_ok = PSEL && hit_rf && idle;
    // Read mux captured at setup, held through access
    if (setup) begin
      unique case (1'b1)
        PADDR == OFF_CTRL: s_nxt.prdata = {16'h0, s_r.cp_size, 4'h0, s_r.wdest,
                                           s_r.size, 1'b0};
        PADDR == OFF_STAT: s_nxt.prdata = {20'h0, s_r.nwords, 3'h0, s_r.regop,
                                           s_r.prog, s_r.illegal, s_r.done, !idle};
        PADDR == OFF_EA: s_nxt.prdata = s_r.ea;
        PADDR == OFF_PC: s_nxt.prdata = s_r.pc;
        PADDR == OFF_OPW: s_nxt.prdata = {16'h0, s_r.opw};
        hit_ext: s_nxt.prdata = {16'h0, s_r.ext[ext_i]};
        default: s_nxt.prdata = '0;
      endcase
    end
    // Setup writes and the start request
    if (acc && PWRITE && idle) begin
      if (PADDR == OFF_CTRL) begin
        s_nxt.size = PWDATA[CTRL_SIZE_LO +: 2];
        s_nxt.wdest = PWDATA[CTRL_WDEST];
        s_nxt.cp_size = PWDATA[CTRL_CP_LO +: 8];
        if (PWDATA[CTRL_START]) begin
          s_nxt.st = S_RBASE;
          s_nxt.done = 1'b0;
          s_nxt.illegal = 1'b0;
          s_nxt.regop = 1'b0;
        end
      end
      if (PADDR == OFF_PC) begin
        s_nxt.pc = PWDATA;
      end
      if (PADDR == OFF_OPW) begin
        s_nxt.opw = PWDATA[15:0];
      end
      if (hit_ext) begin
        s_nxt.ext[ext_i] = PWDATA[15:0];
      end
    end
    unique case (s_r.st)
      S_IDLE: begin
      end
      S_RBASE: begin
        s_nxt.nwords = nw;
        s_nxt.prog = pcm;
        if (illegal) begin
          s_nxt.illegal = 1'b1;
          s_nxt.st = S_DONE;
        end else if (mode == M_DREG || mode == M_AREG) begin
          // Direct modes report the register number, no memory access
          s_nxt.regop = 1'b1;
          s_nxt.ea = {28'h0, mode[0], rn};
          s_nxt.st = S_DONE;
        end else begin
          s_nxt.st = S_RIDX;
        end
      end
      S_RIDX: begin
        s_nxt.base = pcm ? s_r.pc : rf_rdata;
        s_nxt.st = S_CALC;
      end
      S_CALC: begin
        s_nxt.st = S_DONE;
        if (mode == M_AIND) begin
          s_nxt.ea = s_r.base;
        end else if (mode == M_PINC) begin
          s_nxt.ea = s_r.base;
          s_nxt.wb_val = s_r.base + {24'h0, step};
          s_nxt.st = S_WB;
        end else if (mode == M_PDEC) begin
          s_nxt.ea = s_r.base - {24'h0, step};
          s_nxt.wb_val = s_r.base - {24'h0, step};
          s_nxt.st = S_WB;
        end else if (!idxm) begin
          s_nxt.ea = s_r.base + {{16{e0[15]}}, e0};
        end else if (!full || iis == IIS_NONE) begin
          s_nxt.ea = sum;
        end else begin
          // Pointer fetch; postindexed leaves the index for later
          s_nxt.post = !isup && iis[2];
          s_nxt.idx = (!isup && iis[2]) ? it : '0;
          s_nxt.od = disp(s_r.ext, 4'h1 + bdw, iis[1:0]);
          s_nxt.mem.addr = (!isup && iis[2]) ? bt + bd : sum;
          s_nxt.mem.prog = pcm;
          s_nxt.mem.req = 1'b1;
          s_nxt.st = S_MEM;
        end
      end
      S_MEM: begin
        // Request stands until the memory side answers
        if (MEM_ACK) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.ea = MEM_RDATA + s_r.idx + s_r.od;
          s_nxt.st = S_DONE;
        end
      end
      S_WB: begin
        s_nxt.st = S_DONE;
      end
      S_DONE: begin
        s_nxt.valid = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.st = S_IDLE;
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign MEM = s_r.mem;
  assign EA = '{valid: s_r.valid, illegal: s_r.illegal, prog: s_r.prog,
                regop: s_r.regop, addr: s_r.ea};
endmodule // eag_top

// >>> tb/eag_mem_model.sv
// Operand memory model answering pointer fetches
`timescale 1ns/1ps
module eag_mem_model import eag_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire eag_mem_t mem,
  input wire logic [3:0] delay,
  output logic ack,
  output logic [31:0] rdata,
  output logic [31:0] last_addr,
  output int acks
);
  logic [3:0] wait_r;
  // Data line toggles when idle so a stale pointer is never mistaken for a fresh one
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
      wait_r <= 4'h0;
      rdata <= 32'h0;
      last_addr <= 32'h0;
      acks <= 0;
    end else if (ack) begin
      ack <= 1'b0;
      wait_r <= 4'h0;
      rdata <= ~rdata;
    end else if (mem.req && wait_r >= delay) begin
      ack <= 1'b1;
      rdata <= mem.addr + 32'h0010_0000;
      last_addr <= mem.addr;
      acks <= acks + 1;
    end else begin
      wait_r <= mem.req ? wait_r + 4'h1 : 4'h0;
      rdata <= ~rdata;
    end
  end
endmodule // eag_mem_model

// >>> tb/eag_props.sv
// Port checker for the effective address generator
`timescale 1ns/1ps
module eag_props import eag_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire eag_mem_t MEM,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  input wire eag_ea_t EA
);
  logic acc;
  logic hole;
  logic start;
  // Map holes, aligned words only; misaligned use is left open
  assign acc = PSEL && PENABLE && PADDR[1:0] == 2'h0;
  assign hole = (PADDR > OFF_OPW && PADDR < OFF_EXT) || (PADDR > 8'h64 && PADDR < OFF_RF)
                || PADDR > 8'hbc;
  assign start = acc && PWRITE && PREADY && PADDR == OFF_CTRL && PWDATA[CTRL_START];
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  a_hole_refused: assert property (acc && hole |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access accepted");
  a_map_ok: assert property (acc && !hole |-> !PSLVERR)
    else $error("mapped access refused");
  a_reset_idle: assert property ($fell(RST) |-> !MEM.req && EA == '0)
    else $error("state not cleared by reset");
  a_start_result: assert property (start |=> !EA.valid ##1 !EA.valid ##[1:40] EA.valid)
    else $error("no result after start");
  a_valid_pulse: assert property (EA.valid |=> !EA.valid)
    else $error("result strobe too long");
  a_req_hold: assert property (MEM.req && !MEM_ACK |=> MEM.req && $stable(MEM.addr))
    else $error("pointer request changed before ack");
  a_ack_result: assert property (MEM.req && MEM_ACK |=> !MEM.req ##1 EA.valid)
    else $error("result not two cycles after ack");
  a_regop_addr: assert property (EA.valid && EA.regop |-> EA.addr[31:4] == 28'h0)
    else $error("register operand address too wide");
  a_result_hold: assert property (EA.valid && !(acc && PADDR == OFF_CTRL) |=> $stable(EA.addr))
    else $error("result address not held");
  c_mem: cover property (MEM.req && MEM_ACK);
  c_ill: cover property (EA.valid && EA.illegal);
  c_prog: cover property (EA.valid && EA.prog);
endmodule // eag_props

bind eag_top eag_props props_u (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MEM(MEM), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .EA(EA));

// >>> tb/eag_tb_top.sv
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module eag_tb_top import eag_pkg::*; ;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  eag_mem_t mem;
  eag_ea_t ea;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic [31:0] last_addr;
  logic [3:0] mem_delay = 4'h0;
  int acks;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] stat_q;
  logic [31:0] ea_q;

  always #20 clock = ~clock;

  eag_top dut_u (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MEM(mem), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .EA(ea));
  eag_mem_model mem_u (.clk(clock), .rst(rst), .mem(mem), .delay(mem_delay), .ack(mem_ack),
    .rdata(mem_rdata), .last_addr(last_addr), .acks(acks));

  // Register file image, distinct low words to exercise sign extension
  function automatic logic [31:0] rfv(input int i);
    return 32'(i) * 32'h0001_0000 + 32'h0000_fff0 + 32'(i);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Read before this edge's updates land, so these are the sampled values
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) chk("pready_wait", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Load, start, poll done, then compare the illegal flag alone if fl[0] is set, else flags {regop,prog,illegal} and address
  task automatic run(input logic [5:0] op, input logic [31:0] ctl, input logic [15:0] e0,
                     input logic [15:0] e1, input logic [15:0] e2, input logic [31:0] x,
                     input logic [2:0] fl);
    int n;
    n = 0;
    for (int i = 0; i < NUM_RF; i++) wr(OFF_RF + 8'(4 * i), rfv(i));
    wr(OFF_PC, 32'h0000_4000);
    wr(OFF_OPW, {26'h0, op});
    wr(OFF_EXT, {16'h0, e0});
    wr(OFF_EXT + 8'h04, {16'h0, e1});
    wr(OFF_EXT + 8'h08, {16'h0, e2});
    wr(OFF_CTRL, ctl | 32'h1);
    stat_q = 32'h0;
    while (stat_q[1] !== 1'b1 && n < 50) begin
      rd(OFF_STAT, stat_q);
      n++;
    end
    if (n >= 50) chk("done_wait", 32'h1, 32'h0);
    chk("busy", 32'h0, {31'h0, stat_q[0]});
    rd(OFF_EA, ea_q);
    if (fl[0]) begin
      chk("illegal", 32'h1, {31'h0, stat_q[2]});
      chk("ea_illegal", 32'h1, {31'h0, ea.illegal});
    end else begin
      chk("flags", {29'h0, fl}, {29'h0, stat_q[4:2]});
      chk("ea_flags", {29'h0, fl}, {29'h0, ea.regop, ea.prog, ea.illegal});
      chk("ea_reg", x, ea_q);
      chk("ea_port", x, ea.addr);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    failures++;
    results();
  end

  initial begin
    logic [31:0] q;
    logic [31:0] ix;
    logic [31:0] p;
    logic e;
    int n0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("ea_reset", 32'h0, ea.addr);
    chk("req_reset", 32'h0, {31'h0, mem.req});
    rd(OFF_STAT, q);
    chk("stat_reset", 32'h0, q);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("hole_data", 32'h0, q);
    run(6'h03, 32'h0, 16'h0, 16'h0, 16'h0, 32'h3, 3'h4);
    chk("nwords_reg", 32'h0, {28'h0, stat_q[11:8]});
    run(6'h0a, 32'h0, 16'h0, 16'h0, 16'h0, 32'ha, 3'h4);
    run(6'h12, 32'h0, 16'h0, 16'h0, 16'h0, rfv(10), 3'h0);
    run(6'h1a, 32'h4, 16'h0, 16'h0, 16'h0, rfv(10), 3'h0);
    rd(OFF_RF + 8'h28, q);
    chk("postinc_long", rfv(10) + 32'h4, q);
    run(6'h1f, 32'h0, 16'h0, 16'h0, 16'h0, rfv(15), 3'h0);
    rd(OFF_RF + 8'h3c, q);
    chk("postinc_sp", rfv(15) + 32'h2, q);
    run(6'h1a, 32'hff00, 16'h0, 16'h0, 16'h0, rfv(10), 3'h0);
    rd(OFF_RF + 8'h28, q);
    chk("postinc_cp", rfv(10) + 32'hff, q);
    rd(OFF_CTRL, q);
    chk("ctrl_rd", 32'h0000_ff00, q);
    rd(OFF_OPW, q);
    chk("opw_rd", 32'h0000_001a, q);
    rd(OFF_PC, q);
    chk("pc_rd", 32'h0000_4000, q);
    run(6'h27, 32'h0, 16'h0, 16'h0, 16'h0, rfv(15) - 32'h2, 3'h0);
    run(6'h22, 32'h2, 16'h0, 16'h0, 16'h0, rfv(10) - 32'h2, 3'h0);
    run(6'h2a, 32'h0, 16'h8000, 16'h0, 16'h0, rfv(10) + 32'hffff_8000, 3'h0);
    run(6'h3a, 32'h0, 16'h0010, 16'h0, 16'h0, 32'h0000_4010, 3'h2);
    run(6'h3a, 32'h8, 16'h0010, 16'h0, 16'h0, 32'h0, 3'h1);
    run(6'h3b, 32'h0, 16'h3004, 16'h0, 16'h0, 32'h0000_3ff7, 3'h2);
    // Brief index: every type, size and scale code
    for (int k = 0; k < 16; k++) begin
      ix = k[3] ? rfv(11) : rfv(3);
      ix = k[2] ? ix : {{16{ix[15]}}, ix[15:0]};
      run(6'h32, 32'h0, {k[3], 3'h3, k[2], k[1:0], 1'b0, 8'hf0}, 16'h0, 16'h0,
          rfv(10) + 32'hffff_fff0 + (ix << k[1:0]), 3'h0);
    end
    n0 = acks;
    run(6'h32, 32'h0, 16'h1bb0, 16'h1234, 16'h5678, 32'h1234_5678 + (rfv(1) << 1), 3'h0);
    run(6'h32, 32'h0, 16'h0160, 16'hff00, 16'h0, rfv(10) + 32'hffff_ff00, 3'h0);
    run(6'h32, 32'h0, 16'h01d0, 16'h0, 16'h0, 32'h0, 3'h0);
    chk("no_indirect", 32'(n0), 32'(acks));
    run(6'h32, 32'h0, 16'h0180, 16'h0, 16'h0, 32'h0, 3'h1);
    mem_delay <= 4'h5;
    p = rfv(10) + 32'hffff_fffe + 32'hffff_fff3;
    run(6'h32, 32'h0, 16'h3122, 16'hfffe, 16'h0008, p + 32'h0010_0008, 3'h0);
    chk("pre_ptr", p, last_addr);
    chk("nwords_full", 32'h3, {28'h0, stat_q[11:8]});
    mem_delay <= 4'h0;
    p = rfv(10) + 32'hffff_fffe;
    run(6'h32, 32'h0, 16'h3126, 16'hfffe, 16'h0008, p + 32'h000f_fffb, 3'h0);
    chk("post_ptr", p, last_addr);
    chk("ptr_data", 32'h0, {31'h0, mem.prog});
    run(6'h32, 32'h0, 16'h3161, 16'hfffe, 16'h0, p + 32'h0010_0000, 3'h0);
    run(6'h32, 32'h0, 16'h3124, 16'hfffe, 16'h0, 32'h0, 3'h1);
    run(6'h32, 32'h0, 16'h3165, 16'hfffe, 16'h0, 32'h0, 3'h1);
    run(6'h3b, 32'h0, 16'h0161, 16'h0010, 16'h0, 32'h0010_4010, 3'h2);
    chk("pc_ptr", 32'h0000_4010, last_addr);
    chk("ptr_prog", 32'h1, {31'h0, mem.prog});
    results();
  end
endmodule // eag_tb_top
